// ### hdl/imcdv_ctrl.sv
// Interrupt trigger modes, pending-flag clear port and micro-DMA start vector assignment
//
// Behaviour
// - Priority codes 1-6 give levels; 0,7 disable
// - NMI on falling edge, or both when enabled
// - Clear-port write clears that vector's pending flag
// - Four read/write six-bit channel vectors, reset zero
// - Matching source starts DMA, not an interrupt
// - Transfer end interrupts and clears channel vector
// - Shared vector: lowest channel number wins
// - Cleared lower channel hands source to next
// - EXT_IRQ_ZERO level mode bypasses flag, clears it
// - Clear port never clears serial receive flags
`timescale 1ns/100ps
`default_nettype none
module imcdv_ctrl (
  // Clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   reset,
  // Register bus
  input  wire imcdv_pkg::imcdv_axi_req_t              axiReq,
  output var  imcdv_pkg::imcdv_axi_rsp_t              axiRsp,
  // Pins, synchronous to sys_clk
  input  wire logic                                   int0Pin,
  input  wire logic                                   pinIsIrq,
  input  wire logic                                   nmiPin,
  // Peripheral request pulses and receive buffer reads
  input  wire logic [imcdv_pkg::NUM_VEC-1:0]          periphReq,
  input  wire logic [imcdv_pkg::NUM_RX-1:0]           rxBufRead,
  // CPU core
  output logic                                        intReqValid,
  output logic [5:0]                                  intReqVector,
  output logic [2:0]                                  intReqLevel,
  input  wire logic                                   intAck,
  input  wire logic [5:0]                             intAckVector,
  output logic                                        nmiReq,
  input  wire logic                                   nmiAck,
  // Micro-DMA engine
  output logic [imcdv_pkg::NUM_CH-1:0]                dmaStart,
  input  wire logic [imcdv_pkg::NUM_CH-1:0]           dmaDone,
  // Event interrupt
  output logic                                        irq
);
  import imcdv_pkg::*;

  imcdv_state_t         s;
  imcdv_state_t         next_s;
  logic                 wrFire;
  logic [9:0]           wrIdx;
  logic [9:0]           rdIdx;
  logic                 clrFire;
  logic [5:0]           clrVec;
  logic                 isRx;
  logic                 int0Hit;
  logic                 nmiHit;
  logic [NUM_VEC-1:0]   srcSet;
  logic [NUM_VEC-1:0]   srcClr;
  logic [NUM_VEC-1:0]   taken;
  logic [NUM_VEC-1:0]   assigned;
  logic [EVT_W-1:0]     evtClr;
  logic [31:0]          rdData;
  logic                 rdOk;
  logic                 wrOk;
  logic [2:0]           bestLvl;
  logic [5:0]           bestVec;
  logic [2:0]           lvl;
  logic                 req;
  logic [5:0]           prioIdx;

  always_comb begin
    next_s   = s;
    wrFire   = s.awHeld && s.wHeld;
    wrIdx    = s.awAddr[ADDR_W-1:2];
    rdIdx    = axiReq.araddr[ADDR_W-1:2];
    clrFire  = 1'b0;
    clrVec   = s.wData[VEC_W-1:0];
    isRx     = 1'b0;
    srcClr   = '0;
    srcSet   = periphReq;
    taken    = '0;
    assigned = '0;
    evtClr   = '0;
    rdData   = '0;
    rdOk     = 1'b1;
    wrOk     = 1'b1;
    bestLvl  = '0;
    bestVec  = '0;
    lvl      = '0;
    req      = 1'b0;
    prioIdx  = s.prioSel;
    next_s.dmaStart = '0;

    // Address and data are taken in either order, then the write is done
    if (axiReq.awvalid && s.rsp.awready) begin
      next_s.awHeld      = 1'b1;
      next_s.awAddr      = axiReq.awaddr;
      next_s.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && s.rsp.wready) begin
      next_s.wHeld      = 1'b1;
      next_s.wData      = axiReq.wdata;
      next_s.wStrb      = axiReq.wstrb;
      next_s.rsp.wready = 1'b0;
    end
    if (wrFire) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      if (wrIdx[9:2] == IDX_DMA_CH0_VEC[9:2]) begin
        if (s.wStrb[0])
          next_s.dmaVec[wrIdx[1:0]] = s.wData[VEC_W-1:0];
      end else begin
        case (wrIdx)
          IDX_CLEAR_PORT:  clrFire = s.wStrb[0];
          IDX_MODE_CTRL:   if (s.wStrb[0]) next_s.mode = imcdv_mode_t'(s.wData[2:0]);
          IDX_EVT_CLEAR:   if (s.wStrb[0]) evtClr = s.wData[EVT_W-1:0];
          IDX_EVT_ENABLE:  if (s.wStrb[0]) next_s.evtEn = s.wData[EVT_W-1:0];
          IDX_PRIO_ACCESS: begin
            if (s.wStrb[1]) begin
              prioIdx        = s.wData[PRIO_SEL_LSB +: VEC_W];
              next_s.prioSel = prioIdx;
            end
            if (s.wStrb[0])
              next_s.prio[prioIdx] = s.wData[PRIO_CODE_LSB +: 3];
          end
          IDX_EVT_STATUS, IDX_PEND_LO, IDX_PEND_HI: wrOk = 1'b1;
          default: wrOk = 1'b0;
        endcase
      end
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = wrOk ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rsp.bvalid && axiReq.bready) begin
      next_s.rsp.bvalid  = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready  = 1'b1;
    end

    // Read path; write-only registers read as zero
    if (rdIdx[9:2] == IDX_DMA_CH0_VEC[9:2]) begin
      rdData[VEC_W-1:0] = s.dmaVec[rdIdx[1:0]];
    end else begin
      case (rdIdx)
        IDX_CLEAR_PORT, IDX_MODE_CTRL, IDX_EVT_CLEAR: rdData = '0;
        IDX_EVT_STATUS:  rdData[EVT_W-1:0] = s.evtStat;
        IDX_EVT_ENABLE:  rdData[EVT_W-1:0] = s.evtEn;
        IDX_PRIO_ACCESS: begin
          rdData[PRIO_SEL_LSB +: VEC_W] = s.prioSel;
          rdData[PRIO_CODE_LSB +: 3]    = s.prio[s.prioSel];
        end
        IDX_PEND_LO:     rdData = s.pend[31:0];
        IDX_PEND_HI:     rdData = s.pend[63:32];
        default:         rdOk = 1'b0;
      endcase
    end
    if (axiReq.arvalid && s.rsp.arready) begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid  = 1'b1;
      next_s.rsp.rdata   = rdData;
      next_s.rsp.rresp   = rdOk ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rsp.rvalid && axiReq.rready) begin
      next_s.rsp.rvalid  = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // Pin edges against the previous sample
    int0Hit = pinIsIrq && !s.mode.levelSel &&
              (s.mode.edgeSel ? (s.int0Prev && !int0Pin) : (!s.int0Prev && int0Pin));
    nmiHit  = (s.nmiPrev && !nmiPin) || (s.mode.nmiBothEdge && !s.nmiPrev && nmiPin);
    next_s.int0Prev = int0Pin;
    next_s.nmiPrev  = nmiPin;
    next_s.nmiPend  = (s.nmiPend && !nmiAck) || nmiHit;
    srcSet[VEC_EXT_IRQ_ZERO] = srcSet[VEC_EXT_IRQ_ZERO] | int0Hit;

    // Receive flags clear on a buffer read, never through the clear port
    for (int r = 0; r < NUM_RX; r++) begin
      if (clrVec == VEC_SERIAL_RX[r])
        isRx = 1'b1;
      if (rxBufRead[r])
        srcClr[VEC_SERIAL_RX[r]] = 1'b1;
    end
    if (clrFire && !isRx)
      srcClr[clrVec] = 1'b1;
    if (intAck)
      srcClr[intAckVector] = 1'b1;

    // Lowest channel claims a shared vector first; a cleared channel lets the next one take it
    for (int c = 0; c < NUM_CH; c++) begin
      if (s.dmaVec[c] != '0) begin
        assigned[s.dmaVec[c]] = 1'b1;
        if (s.pend[s.dmaVec[c]] && !taken[s.dmaVec[c]]) begin
          taken[s.dmaVec[c]]  = 1'b1;
          srcClr[s.dmaVec[c]] = 1'b1;
          next_s.dmaStart[c]  = 1'b1;
        end
      end
      if (dmaDone[c]) begin
        next_s.dmaVec[c]       = '0;
        srcSet[VEC_DMA_END[c]] = 1'b1;
      end
    end

    // Set wins over clear
    next_s.pend = (s.pend & ~srcClr) | srcSet;
    if (next_s.mode.levelSel)
      next_s.pend[VEC_EXT_IRQ_ZERO] = 1'b0;

    next_s.evtStat = (s.evtStat & ~evtClr) |
                     {int0Hit, nmiHit, dmaDone};
    next_s.irq     = |(next_s.evtStat & next_s.evtEn);

    // Highest enabled level wins, ties go to the lower vector
    for (int v = 0; v < NUM_VEC; v++) begin
      lvl = imcdv_prio_level(s.prio[v]);
      if (6'(v) == VEC_EXT_IRQ_ZERO && s.mode.levelSel)
        req = pinIsIrq && (int0Pin ^ s.mode.edgeSel);
      else
        req = s.pend[v];
      if (req && !assigned[v] && lvl > bestLvl) begin
        bestLvl = lvl;
        bestVec = 6'(v);
      end
    end
    next_s.intReqValid  = bestLvl != '0;
    next_s.intReqVector = bestVec;
    next_s.intReqLevel  = bestLvl;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset)
      s <= IMCDV_RST;
    else
      s <= next_s;
  end

  assign axiRsp       = s.rsp;
  assign intReqValid  = s.intReqValid;
  assign intReqVector = s.intReqVector;
  assign intReqLevel  = s.intReqLevel;
  assign nmiReq       = s.nmiPend;
  assign dmaStart     = s.dmaStart;
  assign irq          = s.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_prio_level_range: assert property (
    s.intReqValid |-> (s.intReqLevel == imcdv_prio_level($past(s.prio[bestVec]))) &&
                      (s.intReqLevel inside {[3'h1:3'h6]}))
    else $error("request level does not match the decoded priority code");

  chk_nmi_falling_edge: assert property (
    (s.nmiPrev && !nmiPin) |=> s.nmiPend)
    else $error("NMI falling edge did not raise a request");

  chk_nmi_rising_ignored: assert property (
    (!s.nmiPrev && nmiPin && !s.mode.nmiBothEdge && !s.nmiPend) |=> !s.nmiPend)
    else $error("NMI rising edge raised a request with both-edge disabled");

  chk_ext_irq_zero_rising_edge: assert property (
    (pinIsIrq && s.mode == 3'b000 && !s.int0Prev && int0Pin) |=> s.pend[VEC_EXT_IRQ_ZERO] || s.mode.levelSel)
    else $error("EXT_IRQ_ZERO rising edge did not set its flag");

  chk_clear_port_flag: assert property (
    (clrFire && !isRx && !srcSet[clrVec]) |=> !s.pend[$past(clrVec)])
    else $error("clear port write left the flag pending");

  chk_chan_vec_write: assert property (
    (wrFire && s.wStrb[0] && wrIdx == IDX_DMA_CH0_VEC && !dmaDone[0]) |=> s.dmaVec[0] == $past(s.wData[5:0]))
    else $error("channel 0 vector write not stored");

  chk_dma_start_match: assert property (
    (s.dmaVec[0] != '0 && s.pend[s.dmaVec[0]]) |=> dmaStart[0] ##1 (!dmaStart[0] || $past(s.pend[s.dmaVec[0]])))
    else $error("matching source did not start channel 0");

  chk_done_clears_vec: assert property (
    dmaDone[0] |=> (s.dmaVec[0] == '0) && s.pend[VEC_DMA_END[0]] && s.evtStat[EVT_DMA_LSB])
    else $error("transfer end did not clear the vector and raise its interrupt");

  chk_shared_low_wins: assert property (
    (s.dmaVec[0] == s.dmaVec[1] && s.dmaVec[0] != '0 && s.pend[s.dmaVec[0]]) |=> dmaStart[0] && !dmaStart[1])
    else $error("shared vector did not go to the lower channel");

  chk_chain_next_chan: assert property (
    (s.dmaVec[0] == '0 && s.dmaVec[1] != '0 && s.pend[s.dmaVec[1]]) |=> dmaStart[1])
    else $error("cleared lower channel did not pass the source on");

  chk_ext_irq_zero_level_flag: assert property (
    s.mode.levelSel |-> !s.pend[VEC_EXT_IRQ_ZERO])
    else $error("EXT_IRQ_ZERO flag held while in level mode");

  chk_rx_flag_kept: assert property (
    (s.pend[VEC_SERIAL_RX[0]] && !rxBufRead[0]) |=> s.pend[VEC_SERIAL_RX[0]])
    else $error("serial receive flag lost without a buffer read");
endmodule : imcdv_ctrl
`default_nettype wire

// ### inc/imcdv_pkg.sv
// Package: register map, types and constants of the interrupt mode, clear and DMA vector block
package imcdv_pkg;
  localparam int NUM_VEC = 64;
  localparam int NUM_CH  = 4;
  localparam int NUM_RX  = 3;
  localparam int ADDR_W  = 12;
  localparam int EVT_W   = 6;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_DMA_CH0_VEC = 10'h080;
  localparam logic [9:0] IDX_DMA_CH1_VEC = 10'h081;
  localparam logic [9:0] IDX_DMA_CH2_VEC = 10'h082;
  localparam logic [9:0] IDX_DMA_CH3_VEC = 10'h083;
  localparam logic [9:0] IDX_CLEAR_PORT  = 10'h088;
  localparam logic [9:0] IDX_MODE_CTRL   = 10'h08C;
  localparam logic [9:0] IDX_EVT_STATUS  = 10'h090;
  localparam logic [9:0] IDX_EVT_CLEAR   = 10'h091;
  localparam logic [9:0] IDX_EVT_ENABLE  = 10'h092;
  localparam logic [9:0] IDX_PRIO_ACCESS = 10'h093;
  localparam logic [9:0] IDX_PEND_LO     = 10'h094;
  localparam logic [9:0] IDX_PEND_HI     = 10'h095;

  // Field positions
  localparam int VEC_W         = 6;
  localparam int PRIO_CODE_LSB = 0;
  localparam int PRIO_SEL_LSB  = 8;
  localparam int EVT_DMA_LSB   = 0;
  localparam int EVT_NMI_BIT   = 4;
  localparam int EVT_EXT_IRQ_ZERO_BIT  = 5;

  // Source vectors
  localparam logic [5:0]                   VEC_EXT_IRQ_ZERO = 6'h0A;
  localparam logic [NUM_CH-1:0][5:0]       VEC_DMA_END      = {6'h2B, 6'h2A, 6'h29, 6'h28};
  localparam logic [NUM_RX-1:0][5:0]       VEC_SERIAL_RX    = {6'h24, 6'h22, 6'h20};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } imcdv_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } imcdv_axi_rsp_t;

  // Bit 2 edge select, bit 1 level select, bit 0 NMI both edges
  typedef struct packed {
    logic edgeSel;
    logic levelSel;
    logic nmiBothEdge;
  } imcdv_mode_t;

  typedef struct packed {
    imcdv_axi_rsp_t                rsp;
    logic                          awHeld;
    logic [ADDR_W-1:0]             awAddr;
    logic                          wHeld;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    imcdv_mode_t                   mode;
    logic [NUM_CH-1:0][5:0]        dmaVec;
    logic [NUM_VEC-1:0][2:0]       prio;
    logic [5:0]                    prioSel;
    logic [NUM_VEC-1:0]            pend;
    logic                          nmiPend;
    logic                          int0Prev;
    logic                          nmiPrev;
    logic [EVT_W-1:0]              evtStat;
    logic [EVT_W-1:0]              evtEn;
    logic                          irq;
    logic [NUM_CH-1:0]             dmaStart;
    logic                          intReqValid;
    logic [5:0]                    intReqVector;
    logic [2:0]                    intReqLevel;
  } imcdv_state_t;

  localparam imcdv_state_t IMCDV_RST = '{
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    nmiPrev: 1'b1,
    default: '0
  };

  // Codes 1..6 give that level; 0 and 7 disable the source
  function automatic logic [2:0] imcdv_prio_level(input logic [2:0] code);
    return (code == 3'h7) ? 3'h0 : code;
  endfunction : imcdv_prio_level
endpackage : imcdv_pkg

// ### tb/imcdv_far_end.sv
// Far-side model: CPU core acknowledging requests and micro-DMA engine ending transfers
`timescale 1ns/100ps
`default_nettype none
module imcdv_far_end #(
  parameter int CNT = 2
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Bench control
  input  wire logic       ackEn,
  // Controller side
  input  wire logic       intReqValid,
  input  wire logic [5:0] intReqVector,
  input  wire logic       nmiReq,
  input  wire logic [3:0] dmaStart,
  output logic            intAck,
  output logic [5:0]      intAckVector,
  output logic            nmiAck,
  output logic [3:0]      dmaDone
);
  int   left [4];
  logic ackHold;
  // Core takes requests only while the bench lets it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      intAck       <= 1'b0;
      intAckVector <= 6'h0;
      nmiAck       <= 1'b0;
      dmaDone      <= 4'h0;
      ackHold      <= 1'b0;
      left         <= '{default: CNT};
    end else begin
      // Request output lags the flag clear, so skip the cycle after an ack
      ackHold      <= intAck;
      intAck       <= ackEn & intReqValid & ~intAck & ~ackHold;
      // Vector is meaningless without the ack, so it keeps moving
      intAckVector <= (ackEn & intReqValid & ~intAck & ~ackHold) ? intReqVector : ~intAckVector;
      nmiAck       <= ackEn & nmiReq & ~nmiAck;
      for (int c = 0; c < 4; c++) begin
        dmaDone[c] <= dmaStart[c] && left[c] == 1;
        if (dmaStart[c]) begin
          left[c] <= (left[c] == 1) ? CNT : left[c] - 1;
        end
      end
    end
  end
endmodule : imcdv_far_end
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the interrupt mode, clear and DMA vector block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import imcdv_pkg::*;
  logic           sys_clk, reset, int0Pin, pinIsIrq, nmiPin, ackEn;
  logic           intReqValid, intAck, nmiReq, nmiAck, irq;
  logic [5:0]     intReqVector, intAckVector;
  logic [2:0]     intReqLevel, rxBufRead;
  logic [63:0]    periphReq;
  logic [3:0]     dmaStart, dmaDone;
  imcdv_axi_req_t axiReq;
  imcdv_axi_rsp_t axiRsp;
  logic [31:0]    rd;
  logic [1:0]     rr;
  int             n_errors = 0;
  int             tests_run = 0;
  int             startCnt [4] = '{default: 0};

  imcdv_ctrl DUT (.sys_clk, .reset, .axiReq, .axiRsp, .int0Pin, .pinIsIrq, .nmiPin, .periphReq,
    .rxBufRead, .intReqValid, .intReqVector, .intReqLevel, .intAck, .intAckVector, .nmiReq,
    .nmiAck, .dmaStart, .dmaDone, .irq);
  imcdv_far_end uFar (.sys_clk, .reset, .ackEn, .intReqValid, .intReqVector, .nmiReq,
    .dmaStart, .intAck, .intAckVector, .nmiAck, .dmaDone);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (dmaStart[c] === 1'b1) startCnt[c]++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= {idx, 2'h0};
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) break;
    end
    rr = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    if (i == 50) begin
      n_errors++;
      conclude();
    end
  endtask : wr
  task automatic rdr(input logic [9:0] idx);
    int i;
    @(posedge sys_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= {idx, 2'h0};
    axiReq.rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) break;
    end
    rd = axiRsp.rdata;
    axiReq.rready <= 1'b0;
    if (i == 50) begin
      n_errors++;
      conclude();
    end
  endtask : rdr
  task automatic pulse(input int v);
    @(posedge sys_clk);
    periphReq[v] <= 1'b1;
    @(posedge sys_clk);
    periphReq[v] <= 1'b0;
  endtask : pulse
  task automatic ack;
    @(posedge sys_clk);
    ackEn <= 1'b1;
    cyc(3);
    ackEn <= 1'b0;
    cyc(2);
  endtask : ack
  task automatic pin(input logic v, input logic nmi);
    @(posedge sys_clk);
    if (nmi) nmiPin <= v;
    else int0Pin <= v;
    cyc(3);
  endtask : pin

  task automatic t_regs;
    for (int c = 0; c < 4; c++) begin
      rdr(IDX_DMA_CH0_VEC + 10'(c));
      chk("chVecReset", rd, 32'h0);
      wr(IDX_DMA_CH0_VEC + 10'(c), 32'hFFFFFFC0 | 32'(c + 1));
      rdr(IDX_DMA_CH0_VEC + 10'(c));
      chk("chVecRw", rd, 32'(c + 1));
      wr(IDX_DMA_CH0_VEC + 10'(c), 32'h0);
    end
    rdr(IDX_CLEAR_PORT);
    chk("clearPortRead", rd, 32'h0);
    wr(10'h0FF, 32'h1);
    chk("unmappedResp", 32'(rr), 32'(RESP_SLVERR));
    $display("Test registers done");
  endtask : t_regs

  task automatic t_clear;
    pulse(6);
    pulse(32);
    wr(IDX_CLEAR_PORT, 32'h6);
    wr(IDX_CLEAR_PORT, 32'h20);
    rdr(IDX_PEND_LO);
    chk("pendCleared", 32'(rd[6]), 32'h0);
    rdr(IDX_PEND_HI);
    chk("rxKept", 32'(rd[0]), 32'h1);
    @(posedge sys_clk);
    rxBufRead <= 3'h1;
    @(posedge sys_clk);
    rxBufRead <= 3'h0;
    rdr(IDX_PEND_HI);
    chk("rxReadClears", 32'(rd[0]), 32'h0);
    $display("Test clear port done");
  endtask : t_clear

  task automatic t_prio;
    pulse(3);
    wr(IDX_PRIO_ACCESS, 32'h300);
    for (int k = 0; k < 8; k++) begin
      wr(IDX_PRIO_ACCESS, 32'h300 | 32'(k));
      cyc(3);
      chk("reqValid", 32'(intReqValid), 32'(k > 0 && k < 7));
      chk("reqLevel", 32'(intReqLevel), (k > 0 && k < 7) ? 32'(k) : 32'h0);
    end
    wr(IDX_PRIO_ACCESS, 32'h305);
    cyc(3);
    chk("reqVector", 32'(intReqVector), 32'h3);
    ack();
    rdr(IDX_PEND_LO);
    chk("ackClears", 32'(rd[3]), 32'h0);
    $display("Test priority done");
  endtask : t_prio

  task automatic t_dma;
    wr(IDX_DMA_CH0_VEC, 32'h5);
    wr(IDX_DMA_CH1_VEC, 32'h5);
    wr(IDX_PRIO_ACCESS, 32'h504);
    wr(IDX_PRIO_ACCESS, 32'h504);
    repeat (2) begin
      pulse(5);
      repeat (4) begin
        @(posedge sys_clk);
        chk("noCpuReq", 32'(intReqValid), 32'h0);
      end
    end
    chk("ch0Starts", startCnt[0], 32'h2);
    chk("ch1Idle", startCnt[1], 32'h0);
    rdr(IDX_DMA_CH0_VEC);
    chk("ch0VecCleared", rd, 32'h0);
    rdr(IDX_EVT_STATUS);
    chk("endStatus", 32'(rd[0]), 32'h1);
    chk("irqMasked", 32'(irq), 32'h0);
    pulse(5);
    cyc(4);
    chk("chainCh1", startCnt[1], 32'h1);
    wr(IDX_EVT_ENABLE, 32'h1);
    cyc(2);
    chk("irqRaised", 32'(irq), 32'h1);
    wr(IDX_EVT_CLEAR, 32'h1);
    cyc(2);
    chk("irqCleared", 32'(irq), 32'h0);
    wr(IDX_DMA_CH0_VEC, 32'h5);
    pulse(5);
    cyc(4);
    chk("ch0Back", startCnt[0], 32'h3);
    $display("Test micro-DMA done");
  endtask : t_dma

  task automatic t_pins;
    wr(IDX_MODE_CTRL, 32'h0);
    pin(1'b1, 1'b0);
    rdr(IDX_PEND_LO);
    chk("int0Rise", 32'(rd[10]), 32'h1);
    wr(IDX_CLEAR_PORT, 32'(VEC_EXT_IRQ_ZERO));
    wr(IDX_MODE_CTRL, 32'h4);
    pin(1'b0, 1'b0);
    rdr(IDX_PEND_LO);
    chk("int0Fall", 32'(rd[10]), 32'h1);
    wr(IDX_MODE_CTRL, 32'h2);
    rdr(IDX_PEND_LO);
    chk("levelClears", 32'(rd[10]), 32'h0);
    wr(IDX_PRIO_ACCESS, 32'hA02);
    wr(IDX_PRIO_ACCESS, 32'hA02);
    pin(1'b1, 1'b0);
    chk("highLevel", {intReqValid, intReqVector}, 32'h4A);
    pin(1'b0, 1'b0);
    chk("highGone", 32'(intReqValid), 32'h0);
    wr(IDX_MODE_CTRL, 32'h6);
    cyc(3);
    chk("lowLevel", 32'(intReqValid), 32'h1);
    wr(IDX_MODE_CTRL, 32'h0);
    pin(1'b0, 1'b1);
    chk("nmiFall", 32'(nmiReq), 32'h1);
    ack();
    pin(1'b1, 1'b1);
    chk("nmiRiseOff", 32'(nmiReq), 32'h0);
    wr(IDX_MODE_CTRL, 32'h1);
    pin(1'b0, 1'b1);
    ack();
    pin(1'b1, 1'b1);
    chk("nmiRiseOn", 32'(nmiReq), 32'h1);
    @(posedge sys_clk);
    pinIsIrq <= 1'b0;
    pin(1'b1, 1'b0);
    rdr(IDX_PEND_LO);
    chk("int0NotIrqPin", 32'(rd[10]), 32'h0);
    pinIsIrq <= 1'b1;
    $display("Test pins done");
  endtask : t_pins

  initial begin
    reset = 1'b1;
    ackEn = 1'b0;
    int0Pin = 1'b0;
    pinIsIrq = 1'b1;
    nmiPin = 1'b1;
    periphReq = 64'h0;
    rxBufRead = 3'h0;
    axiReq = '{wstrb: 4'hF, default: '0};
    cyc(12);
    reset <= 1'b0;
    t_regs();
    t_clear();
    t_prio();
    t_dma();
    t_pins();
    conclude();
  end
endmodule : tb
`default_nettype wire
